// ---- core/srgc_pkg.sv ----
// shared constants and types of the rectifier gate controller
package srgc_pkg;
  // clock rate
  localparam int CLK_PERIOD_NS = 40;
  // timer width, wide enough for the longest window
  localparam int TW = 12;
  localparam logic [TW-1:0] TMAX = {TW{1'b1}};
  // arming time, longest allowed fall time, rounds down
  localparam int T_ARM_NS = 85;
  localparam logic [TW-1:0] ARM_CYC = TW'(T_ARM_NS / CLK_PERIOD_NS);
  // dead-time target
  localparam int T_DEAD_NS = 200;
  localparam logic [TW-1:0] DEAD_CYC = TW'(T_DEAD_NS / CLK_PERIOD_NS);
  // minimum off time, short-period value, rounds up
  localparam int T_OFF_MIN_HI_NS = 1700;
  localparam logic [TW-1:0] OFF_MIN_HI_CYC =
    TW'((T_OFF_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // minimum off time, long-period value, rounds up
  localparam int T_OFF_MIN_LO_NS = 4000;
  localparam logic [TW-1:0] OFF_MIN_LO_CYC =
    TW'((T_OFF_MIN_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // slope disable limit on the switching period
  localparam int T_SLOPE_DIS_NS = 40000;
  localparam logic [TW-1:0] SLOPE_DIS_CYC = TW'(T_SLOPE_DIS_NS / CLK_PERIOD_NS);
  // hysteresis on that limit
  localparam int T_SLOPE_HYS_NS = 4000;
  localparam logic [TW-1:0] SLOPE_HYS_CYC = TW'(T_SLOPE_HYS_NS / CLK_PERIOD_NS);
  // enable window after a gate rising edge
  localparam int T_BOOST_EN_NS = 72000;
  localparam logic [TW-1:0] BOOST_EN_CYC = TW'(T_BOOST_EN_NS / CLK_PERIOD_NS);
  // turn-off threshold levels
  localparam int LEVELS = 32;
  localparam int LW = 5;
  localparam logic [LW-1:0] LEVEL_RST = 5'h10;
  localparam logic [LW-1:0] LEVEL_TOP = LW'(LEVELS - 1);
  // gate sequencing states
  typedef enum logic [1:0] {
    SRGC_HALT = 2'b00,
    SRGC_OFF = 2'b01,
    SRGC_ON = 2'b10
  } srgc_state_t;
  // synchronised comparator levels
  typedef struct packed {
    logic sup_on;
    logic sup_hold;
    logic above_arm;
    logic below_on;
    logic above_off;
    logic above_high;
  } srgc_cmp_t;
endpackage : srgc_pkg

// ---- core/srgc_gate_ctrl.sv ----
// rectifier gate timing, slope qualification and dead-time tuning
//
// Operation
// [RULE1] the gate rises only when permission, trigger and slope qualifier all hold.
// [RULE2] permission comes once the minimum off time has run since the last gate fall.
// [RULE3] the trigger is active once the drain is below the turn-on threshold.
// [RULE4] the gate falls when the drain rises above the current turn-off threshold.
// [RULE5] with slope detection on, turn-on needs the arm-to-on fall shorter than the arm time.
// [RULE6] slope detection stays on while the period is below limit minus hysteresis.
// [RULE7] at or above the limit it is on only from a gate rise to the end of the window.
// [RULE8] the blanking length follows the last gate-to-gate period.
// [RULE9] short periods use the high off-time value, long ones past the hysteresis the low.
// [RULE10] a 32-level up/down counter picks the turn-off threshold each cycle.
// [RULE11] each cycle the gate-fall to high-threshold time is measured against the target.
// [RULE12] a dead time above target steps the counter up by one.
// [RULE13] operation starts at the supply on level and stops at the supply off level.
// [RULE14] until operation starts the gate is held low and clamped.
// [RULE15] the dead-time target is 200 ns.
// [RULE16] a dead time below target steps the counter down, saturating at both ends.
`timescale 1ns/100ps
module srgc_gate_ctrl
  import srgc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sup_on_i,
  input wire logic sup_hold_i,
  input wire logic above_arm_i,
  input wire logic below_on_i,
  input wire logic above_off_i,
  input wire logic above_high_i,
  output logic gate_o,
  output logic clamp_o,
  output logic [LW-1:0] off_level_o,
  output logic slope_en_o,
  output logic blank_hi_o
);

  // saturating timer step
  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
    sat_inc = (v == TMAX) ? v : v + 12'h001;
  endfunction : sat_inc

  // two-flop synchronisers for every comparator and supply level
  srgc_cmp_t meta_ff;
  srgc_cmp_t cmp_ff;
  srgc_cmp_t cmp_d_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      cmp_ff <= '0;
      cmp_d_ff <= '0;
    end else begin
      meta_ff <= {sup_on_i, sup_hold_i, above_arm_i, below_on_i, above_off_i,
                  above_high_i};
      cmp_ff <= meta_ff;
      cmp_d_ff <= cmp_ff;
    end
  end

  // edges seen on the synchronised levels only
  logic arm_fall;
  logic on_rise;
  logic high_rise;
  assign arm_fall = cmp_d_ff.above_arm & ~cmp_ff.above_arm;
  assign on_rise = ~cmp_d_ff.below_on & cmp_ff.below_on;
  assign high_rise = ~cmp_d_ff.above_high & cmp_ff.above_high;

  // run flag with supply hysteresis
  logic run_ff;
  logic nxt_run;
  always_comb begin
    nxt_run = run_ff;
    if (!run_ff && cmp_ff.sup_on) begin
      nxt_run = 1'b1; // [RULE13]
    end else if (run_ff && !cmp_ff.sup_hold) begin
      nxt_run = 1'b0; // [RULE13]
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
    end
  end

  // state and timers of the gate
  srgc_state_t state_ff;
  srgc_state_t nxt_state;
  logic [TW-1:0] off_tmr_ff;
  logic [TW-1:0] nxt_off_tmr;
  logic [TW-1:0] per_tmr_ff;
  logic [TW-1:0] nxt_per_tmr;
  logic [TW-1:0] per_last_ff;
  logic [TW-1:0] nxt_per_last;
  logic gate_ff;
  logic nxt_gate;
  logic clamp_ff;
  logic nxt_clamp;
  logic gate_rise;
  logic gate_fall;
  logic permit;
  logic trigger;
  logic qualify;
  logic blank_hi_ff;
  logic slope_on;
  logic slope_ok_ff;

  assign trigger = cmp_ff.below_on; // [RULE3]
  // blanking length from the period mode
  assign permit = off_tmr_ff >= (blank_hi_ff ? OFF_MIN_HI_CYC : OFF_MIN_LO_CYC); // [RULE2] [RULE8]
  assign qualify = ~slope_on | slope_ok_ff; // [RULE5]

  always_comb begin
    nxt_state = state_ff;
    nxt_gate = 1'b0;
    nxt_clamp = 1'b1;
    nxt_off_tmr = sat_inc(off_tmr_ff);
    nxt_per_tmr = sat_inc(per_tmr_ff);
    nxt_per_last = per_last_ff;
    gate_rise = 1'b0;
    gate_fall = 1'b0;
    case (state_ff)
      SRGC_HALT: begin
        nxt_off_tmr = '0;
        if (run_ff) begin
          nxt_state = SRGC_OFF;
          nxt_clamp = 1'b0;
        end
      end
      SRGC_OFF: begin
        nxt_clamp = 1'b0;
        if (!run_ff) begin
          nxt_state = SRGC_HALT;
          nxt_clamp = 1'b1; // [RULE14]
        end else if (permit && trigger && qualify) begin
          nxt_state = SRGC_ON; // [RULE1]
          nxt_gate = 1'b1;
          gate_rise = 1'b1;
          nxt_per_last = per_tmr_ff; // [RULE8]
          nxt_per_tmr = '0;
        end
      end
      SRGC_ON: begin
        nxt_clamp = 1'b0;
        nxt_gate = 1'b1;
        if (!run_ff) begin
          nxt_state = SRGC_HALT;
          nxt_gate = 1'b0;
          nxt_clamp = 1'b1; // [RULE14]
          gate_fall = 1'b1;
          nxt_off_tmr = '0;
        end else if (cmp_ff.above_off) begin
          nxt_state = SRGC_OFF; // [RULE4]
          nxt_gate = 1'b0;
          gate_fall = 1'b1;
          nxt_off_tmr = '0; // [RULE2]
        end
      end
      default: begin
        nxt_state = SRGC_HALT;
      end
    endcase
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= SRGC_HALT;
      gate_ff <= 1'b0;
      clamp_ff <= 1'b1;
      off_tmr_ff <= '0;
      per_tmr_ff <= TMAX; // no gate-to-gate period seen yet
      per_last_ff <= TMAX;
    end else begin
      state_ff <= nxt_state;
      gate_ff <= nxt_gate;
      clamp_ff <= nxt_clamp;
      off_tmr_ff <= nxt_off_tmr;
      per_tmr_ff <= nxt_per_tmr;
      per_last_ff <= nxt_per_last;
    end
  end

  // period modes, updated from the last gate-to-gate period
  logic cont_ff;
  logic nxt_cont;
  logic nxt_blank_hi;
  logic [TW-1:0] win_tmr_ff;
  logic [TW-1:0] nxt_win_tmr;
  always_comb begin
    nxt_cont = cont_ff;
    nxt_blank_hi = blank_hi_ff;
    nxt_win_tmr = sat_inc(win_tmr_ff);
    if (per_last_ff < SLOPE_DIS_CYC - SLOPE_HYS_CYC) begin
      nxt_cont = 1'b1; // [RULE6]
    end else if (per_last_ff >= SLOPE_DIS_CYC) begin
      nxt_cont = 1'b0; // [RULE7]
    end
    if (per_last_ff < SLOPE_DIS_CYC) begin
      nxt_blank_hi = 1'b1; // [RULE9]
    end else if (per_last_ff > SLOPE_DIS_CYC + SLOPE_HYS_CYC) begin
      nxt_blank_hi = 1'b0; // [RULE9]
    end
    if (gate_rise) begin
      nxt_win_tmr = '0; // [RULE7]
    end
  end
  // window runs from the gate rise until the enable period ends
  assign slope_on = cont_ff | (win_tmr_ff < BOOST_EN_CYC); // [RULE6] [RULE7]
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cont_ff <= 1'b0;
      blank_hi_ff <= 1'b0;
      win_tmr_ff <= TMAX;
    end else begin
      cont_ff <= nxt_cont;
      blank_hi_ff <= nxt_blank_hi;
      win_tmr_ff <= nxt_win_tmr;
    end
  end

  // slope timer from the arm crossing to the on crossing
  logic [TW-1:0] slope_tmr_ff;
  logic [TW-1:0] nxt_slope_tmr;
  logic slope_run_ff;
  logic nxt_slope_run;
  logic nxt_slope_ok;
  always_comb begin
    nxt_slope_tmr = slope_run_ff ? sat_inc(slope_tmr_ff) : slope_tmr_ff;
    nxt_slope_run = slope_run_ff;
    nxt_slope_ok = slope_ok_ff;
    if (arm_fall) begin
      nxt_slope_tmr = '0; // [RULE5]
      // both crossings in one cycle means zero fall time, qualified at once
      nxt_slope_run = ~on_rise;
      nxt_slope_ok = on_rise; // [RULE5]
    end else if (slope_run_ff && on_rise) begin
      nxt_slope_run = 1'b0;
      nxt_slope_ok = slope_tmr_ff < ARM_CYC; // [RULE5]
    end
    // a ringing drain back above arm or a fresh gate cycle rearms the check
    if (cmp_ff.above_arm || gate_fall) begin
      nxt_slope_ok = 1'b0;
      if (!arm_fall) begin
        nxt_slope_run = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slope_tmr_ff <= '0;
      slope_run_ff <= 1'b0;
      slope_ok_ff <= 1'b0;
    end else begin
      slope_tmr_ff <= nxt_slope_tmr;
      slope_run_ff <= nxt_slope_run;
      slope_ok_ff <= nxt_slope_ok;
    end
  end

  // dead-time measurement and turn-off level counter
  logic [TW-1:0] dead_tmr_ff;
  logic [TW-1:0] nxt_dead_tmr;
  logic dead_run_ff;
  logic nxt_dead_run;
  logic [LW-1:0] level_ff;
  logic [LW-1:0] nxt_level;
  // gate fall delayed by two stages to line up with the synchronised drain rise
  logic [1:0] fall_pipe_ff;
  logic [1:0] nxt_fall_pipe;
  always_comb begin
    nxt_dead_tmr = dead_run_ff ? sat_inc(dead_tmr_ff) : dead_tmr_ff;
    nxt_dead_run = dead_run_ff;
    nxt_level = level_ff;
    nxt_fall_pipe = {fall_pipe_ff[0], gate_fall & run_ff};
    if (fall_pipe_ff[1]) begin
      nxt_dead_tmr = '0; // [RULE11]
      nxt_dead_run = 1'b1;
    end else if (dead_run_ff && (gate_rise || !run_ff)) begin
      nxt_dead_run = 1'b0; // cycle abandoned, no step
    end else if (dead_run_ff && high_rise) begin
      nxt_dead_run = 1'b0;
      if (dead_tmr_ff > DEAD_CYC) begin // [RULE11] [RULE15]
        if (level_ff != LEVEL_TOP) begin
          nxt_level = level_ff + 5'h01; // [RULE12] [RULE10]
        end
      end else if (dead_tmr_ff < DEAD_CYC) begin
        if (level_ff != 5'h00) begin
          nxt_level = level_ff - 5'h01; // [RULE16]
        end
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dead_tmr_ff <= '0;
      dead_run_ff <= 1'b0;
      level_ff <= LEVEL_RST;
      fall_pipe_ff <= '0;
    end else begin
      dead_tmr_ff <= nxt_dead_tmr;
      dead_run_ff <= nxt_dead_run;
      level_ff <= nxt_level;
      fall_pipe_ff <= nxt_fall_pipe;
    end
  end

  // registered slope flag for observation
  logic slope_en_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slope_en_ff <= 1'b0;
    end else begin
      slope_en_ff <= slope_on;
    end
  end

  // outputs straight from flops
  assign gate_o = gate_ff;
  assign clamp_o = clamp_ff;
  assign off_level_o = level_ff; // [RULE10]
  assign slope_en_o = slope_en_ff;
  assign blank_hi_o = blank_hi_ff;

endmodule : srgc_gate_ctrl

// ---- test/srgc_gate_ctrl_checker.sv ----
// port-level assertions for the rectifier gate controller
`timescale 1ns/100ps
module srgc_gate_ctrl_checker
  import srgc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sup_on_i,
  input wire logic sup_hold_i,
  input wire logic above_arm_i,
  input wire logic below_on_i,
  input wire logic above_off_i,
  input wire logic above_high_i,
  input wire logic gate_o,
  input wire logic clamp_o,
  input wire logic [LW-1:0] off_level_o,
  input wire logic slope_en_o,
  input wire logic blank_hi_o
);
  logic [TW-1:0] low_cnt_ff;
  logic [TW-1:0] nxt_low_cnt;
  // cycles the gate has stayed low, saturating
  always_comb begin
    nxt_low_cnt = low_cnt_ff;
    if (gate_o) nxt_low_cnt = '0;
    else if (low_cnt_ff != TMAX) nxt_low_cnt = low_cnt_ff + 12'h001;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) low_cnt_ff <= '0;
    else low_cnt_ff <= nxt_low_cnt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_clamp_gate_low: assert property (clamp_o |-> !gate_o)
    else $error("gate high while clamped");
  a_gate_needs_trig: assert property ($rose(gate_o) |-> $past(below_on_i, 3))
    else $error("gate rose without trigger");
  a_gate_turn_off: assert property (above_off_i [*3] |=> !gate_o)
    else $error("gate kept on above off threshold");
  a_gate_min_off: assert property ($rose(gate_o) |-> low_cnt_ff >= OFF_MIN_HI_CYC - 12'h001)
    else $error("gate rose before minimum off time");
  a_level_unit_step: assert property (!$stable(off_level_o) |->
    ({1'b0, off_level_o} == {1'b0, $past(off_level_o)} + 6'h01) ||
    ({1'b0, $past(off_level_o)} == {1'b0, off_level_o} + 6'h01))
    else $error("level moved by more than one");
  a_level_while_off: assert property (!$stable(off_level_o) |-> !gate_o)
    else $error("level moved while gate on");
  a_halt_on_loss: assert property (!sup_hold_i [*4] |=> clamp_o && !gate_o)
    else $error("no halt after supply loss");
  a_run_on_supply: assert property ((sup_on_i && sup_hold_i) [*4] |=> !clamp_o)
    else $error("no start with supply present");
endmodule : srgc_gate_ctrl_checker

// ---- test/srgc_stage_model.sv ----
// power stage model: drain and supply comparators
`timescale 1ns/100ps
module srgc_stage_model
  import srgc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sup_i,
  input wire logic fire_i,
  input wire logic slow_i,
  input wire logic [3:0] dead_i,
  input wire logic gate_i,
  output srgc_cmp_t cmp_o
);
  logic [1:0] ph;
  logic [3:0] cnt;
  initial begin
    ph = 2'h0;
    cnt = 4'h0;
    cmp_o = 6'h0b;
  end
  // drain falls on command, conducts, rings back high after the gate drops
  always @(posedge clk_i) begin
    cmp_o.sup_on <= sup_i;
    cmp_o.sup_hold <= sup_i;
    case (ph)
      2'h0: if (fire_i) begin
        cmp_o.above_arm <= 1'b0;
        cmp_o.above_off <= 1'b0;
        cmp_o.above_high <= 1'b0;
        cmp_o.below_on <= !slow_i;
        cnt <= slow_i ? 4'h4 : 4'ha;
        ph <= slow_i ? 2'h1 : 2'h2;
      end
      2'h1: if (cnt == 4'h0) begin
        cmp_o.below_on <= 1'b1;
        cnt <= 4'ha;
        ph <= 2'h2;
      end else cnt <= cnt - 4'h1;
      2'h2: if (cnt == 4'h0) begin
        cmp_o.below_on <= 1'b0;
        cmp_o.above_off <= 1'b1;
        cnt <= dead_i;
        ph <= 2'h3;
      end else cnt <= cnt - 4'h1;
      default: if (!gate_i) begin
        if (cnt == 4'h0) begin
          cmp_o.above_high <= 1'b1;
          cmp_o.above_arm <= 1'b1;
          ph <= 2'h0;
        end else cnt <= cnt - 4'h1;
      end
    endcase
  end
endmodule : srgc_stage_model

// ---- test/srgc_gate_ctrl_tb.sv ----
// self-checking bench for the rectifier gate controller
`timescale 1ns/100ps
module srgc_gate_ctrl_tb
  import srgc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sup = 1'b0;
  logic fire = 1'b0;
  logic slow = 1'b0;
  logic [3:0] dead = 4'h0;
  logic [3:0] dl;
  srgc_cmp_t cmp;
  logic gate_o, clamp_o, slope_en_o, blank_hi_o;
  logic [LW-1:0] off_level_o;
  logic [LW-1:0] lvl = LEVEL_RST;
  logic exp_q[$];
  logic seen_on = 1'b0;
  logic arm_q = 1'b1;
  int fail_count = 0;
  int checked = 0;
  int seed = 49;
  int n;
  always #20 clk_i = ~clk_i;
  srgc_stage_model u_stage (.clk_i(clk_i), .sup_i(sup), .fire_i(fire), .slow_i(slow),
    .dead_i(dead), .gate_i(gate_o), .cmp_o(cmp));
  srgc_gate_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .sup_on_i(cmp.sup_on),
    .sup_hold_i(cmp.sup_hold), .above_arm_i(cmp.above_arm), .below_on_i(cmp.below_on),
    .above_off_i(cmp.above_off), .above_high_i(cmp.above_high), .gate_o(gate_o),
    .clamp_o(clamp_o), .off_level_o(off_level_o), .slope_en_o(slope_en_o),
    .blank_hi_o(blank_hi_o));
  task automatic check(input logic [LW-1:0] seen, input logic [LW-1:0] expv);
    checked++;
    if (seen !== expv) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // one drain event: note the expected gate result, then wait for the drain to return
  task automatic pulse(input logic s, input logic [3:0] d, input logic e, input int gap);
    int k;
    int dns;
    exp_q.push_back(e);
    fire <= 1'b1;
    slow <= s;
    dead <= d;
    @(posedge clk_i);
    fire <= 1'b0;
    @(posedge clk_i);
    for (k = 0; k < 300 && cmp.above_arm !== 1'b1; k++) @(posedge clk_i);
    if (k == 300) begin
      fail_count++;
      wrap_up();
    end
    repeat (gap) @(posedge clk_i);
    if (e) begin
      // true dead time: one cycle after the gate falls, then d more cycles
      dns = (int'(d) + 1) * CLK_PERIOD_NS;
      if (dns > T_DEAD_NS) lvl = (lvl == LEVEL_TOP) ? lvl : lvl + 5'h01;
      else if (dns < T_DEAD_NS) lvl = (lvl == 5'h00) ? lvl : lvl - 5'h01;
      check(off_level_o, lvl);
    end
  endtask : pulse
  // per event: did the gate fire while the drain was low
  always @(posedge clk_i) begin
    arm_q <= cmp.above_arm;
    if (gate_o === 1'b1) seen_on <= 1'b1;
    if (!arm_q && cmp.above_arm) begin
      seen_on <= 1'b0;
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check(seen_on, exp_q.pop_front());
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    check(clamp_o, 1'b1);
    check(off_level_o, LEVEL_RST);
    rst_i <= 1'b0;
    pulse(1'b0, 4'h0, 1'b0, 20);
    sup <= 1'b1;
    repeat (120) @(posedge clk_i);
    pulse(1'b1, 4'h0, 1'b1, 150);
    pulse(1'b1, 4'h0, 1'b0, 20);
    check(slope_en_o, 1'b1);
    pulse(1'b0, 4'h8, 1'b1, 10);
    check(blank_hi_o, 1'b1);
    pulse(1'b0, 4'h0, 1'b0, 150);
    repeat (2000) @(posedge clk_i);
    check(slope_en_o, 1'b1);
    pulse(1'b1, 4'h0, 1'b0, 20);
    pulse(1'b0, 4'hc, 1'b1, 20);
    check(blank_hi_o, 1'b0);
    check(slope_en_o, 1'b1);
    repeat (2000) @(posedge clk_i);
    check(slope_en_o, 1'b0);
    pulse(1'b1, 4'h4, 1'b1, 150);
    for (n = 0; n < 60; n++) begin
      dl = 4'($unsigned($random(seed)) % 8);
      pulse(1'b0, (n < 24) ? (dl | 4'h8) : (dl & 4'h1), 1'b1, 120);
    end
    exp_q.push_back(1'b1);
    fire <= 1'b1;
    slow <= 1'b0;
    @(posedge clk_i);
    fire <= 1'b0;
    for (n = 0; n < 20 && gate_o !== 1'b1; n++) @(posedge clk_i);
    check(gate_o, 1'b1);
    sup <= 1'b0;
    repeat (7) @(posedge clk_i);
    check(gate_o, 1'b0);
    check(clamp_o, 1'b1);
    repeat (40) @(posedge clk_i);
    wrap_up();
  end
endmodule : srgc_gate_ctrl_tb
bind srgc_gate_ctrl srgc_gate_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .sup_on_i(sup_on_i), .sup_hold_i(sup_hold_i), .above_arm_i(above_arm_i),
  .below_on_i(below_on_i), .above_off_i(above_off_i), .above_high_i(above_high_i),
  .gate_o(gate_o), .clamp_o(clamp_o), .off_level_o(off_level_o),
  .slope_en_o(slope_en_o), .blank_hi_o(blank_hi_o));
